// file: rtl/tcp_compare.sv
`timescale 1ns/1ps
module tcp_compare (
    input  wire logic             CLK,
    input  wire logic             RSTN,
    input  tcp_pkg::tcp_bus_t     BUS,
    output logic [31:0]           RDATA,
    input  wire logic             EXT_TRIG,
    input  wire logic             DBG_HALT,
    input  wire logic             DEBUG_HOLD,
    output logic [tcp_pkg::NCH-1:0] CHAN_OUT,
    output logic                  IRQ,
    output logic                  DMA_REQ
);
    import tcp_pkg::*;

    typedef struct packed {
        logic [2:0]                 trig_sync;
        logic                       filtered_ext_trig;
        logic [3:0]                 ctl;
        logic [31:0]                chctl;
        logic [15:0]                inten;
        logic [NCH-1:0]             chan_match_flag;
        logic [CW-1:0]              cnt;
        logic                       dir_down;
        logic [CW-1:0]              psc_cnt;
        logic [CW-1:0]              psc_pre;
        logic [CW-1:0]              psc_sh;
        logic [CW-1:0]              rel_pre;
        logic [CW-1:0]              rel_sh;
        logic [NCH-1:0][CW-1:0]     cmp_pre;
        logic [NCH-1:0][CW-1:0]     cmp_sh;
        logic [NCH-1:0]             clr_lat;
        logic [NCH-1:0]             chan_prep_sig;
        logic [NCH-1:0]             chan_out;
        logic                       irq;
        logic [5:0]                 dstart;
        logic [4:0]                 dcnt;
        logic [4:0]                 didx;
        logic [4:0]                 dleft;
        logic                       dreq;
        logic [31:0]                rdata;
    } tcp_state_t;

    tcp_state_t     s_reg;
    tcp_state_t     s_next;
    logic [1:0]     rst_q_reg;
    logic           rst_n;
    logic           halted;
    logic           tick;
    logic           upd;
    logic           dma_ev;
    logic           dtb;
    logic [5:0]     widx;
    logic [NCH-1:0] match;
    logic [2:0]     mode;
    logic           up_dir;
    logic [2:0]     ch0_mode;

    assign ch0_mode = s_reg.chctl[CF_MODE +: 3];

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_q_reg <= 2'h0;
        end else begin
            rst_q_reg <= {rst_q_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_q_reg[1];

    always_comb begin
        s_next = s_reg;
        // pin sync: accept a new level once second and third stages agree
        s_next.trig_sync = {s_reg.trig_sync[1:0], EXT_TRIG};
        if (s_reg.trig_sync[1] == s_reg.trig_sync[2]) begin
            s_next.filtered_ext_trig = s_reg.trig_sync[2];
        end
        halted = DBG_HALT & DEBUG_HOLD;
        tick = s_reg.ctl[CTL_RUN] & ~halted & (s_reg.psc_cnt == s_reg.psc_sh);
        upd = 1'b0;
        up_dir = s_reg.ctl[CTL_CENTER] ? ~s_reg.dir_down : ~s_reg.ctl[CTL_DOWN];
        if (s_reg.ctl[CTL_RUN] && !halted) begin
            s_next.psc_cnt = tick ? '0 : s_reg.psc_cnt + 16'h0001;
        end
        if (tick) begin
            if (s_reg.ctl[CTL_CENTER]) begin
                if (!s_reg.dir_down) begin
                    if (s_reg.cnt >= s_reg.rel_sh) begin
                        s_next.dir_down = 1'b1;
                        s_next.cnt = s_reg.cnt - 16'h0001;
                        upd = 1'b1;
                    end else begin
                        s_next.cnt = s_reg.cnt + 16'h0001;
                    end
                end else if (s_reg.cnt == '0) begin
                    s_next.dir_down = 1'b0;
                    s_next.cnt = 16'h0001;
                    upd = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                end
            end else if (s_reg.ctl[CTL_DOWN]) begin
                if (s_reg.cnt == '0) begin
                    s_next.cnt = s_reg.rel_sh;
                    upd = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                end
            end else if (s_reg.cnt >= s_reg.rel_sh) begin
                s_next.cnt = '0;
                upd = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + 16'h0001;
            end
        end
        // bus access, buffer accesses map to the dma target register
        dtb = (BUS.addr[7:2] == IX_DMATB);
        widx = dtb ? s_reg.dstart + 6'(s_reg.didx) : BUS.addr[7:2];
        if (BUS.wr) begin
            case (widx)
                IX_CTL:    s_next.ctl = BUS.wdata[3:0];
                IX_CHCTL:  s_next.chctl = BUS.wdata;
                IX_INTEN:  s_next.inten = BUS.wdata[15:0];
                IX_FLAGS:  s_next.chan_match_flag = s_reg.chan_match_flag & ~BUS.wdata[NCH-1:0];
                IX_RELOAD: s_next.rel_pre = BUS.wdata[CW-1:0];
                IX_PSC:    s_next.psc_pre = BUS.wdata[CW-1:0];
                IX_DMACFG: begin
                    s_next.dstart = BUS.wdata[5:0];
                    s_next.dcnt = BUS.wdata[DC_CNT +: 5];
                end
                default: begin
                    if (widx >= IX_CMP0 && widx < IX_CMP0 + 6'(NCH)) begin
                        s_next.cmp_pre[CHW'(widx - IX_CMP0)] = BUS.wdata[CW-1:0];
                    end
                end
            endcase
        end
        s_next.rdata = 32'h0000_0000;
        if (BUS.rd) begin
            case (widx)
                IX_CTL:    s_next.rdata = 32'(s_reg.ctl);
                IX_CHCTL:  s_next.rdata = s_reg.chctl;
                IX_INTEN:  s_next.rdata = 32'(s_reg.inten);
                IX_FLAGS:  s_next.rdata = 32'(s_reg.chan_match_flag);
                IX_COUNT:  s_next.rdata = 32'(s_reg.cnt);
                IX_RELOAD: s_next.rdata = 32'(s_reg.rel_pre);
                IX_PSC:    s_next.rdata = 32'(s_reg.psc_pre);
                IX_DMACFG: s_next.rdata = 32'({s_reg.dcnt, 2'h0, s_reg.dstart});
                default: begin
                    if (widx >= IX_CMP0 && widx < IX_CMP0 + 6'(NCH)) begin
                        s_next.rdata = 32'(s_reg.cmp_pre[CHW'(widx - IX_CMP0)]);
                    end
                end
            endcase
        end
        // shadow loads
        if (upd) begin
            s_next.psc_sh = s_reg.psc_pre;
            s_next.rel_sh = s_reg.rel_pre;
        end
        if (!s_reg.ctl[CTL_ARSE]) begin
            s_next.rel_sh = s_next.rel_pre;
        end
        dma_ev = 1'b0;
        match = '0;
        mode = OC_FREEZE;
        for (int i = 0; i < NCH; i++) begin
            if (!s_reg.chctl[i*CH_STRIDE+CF_SHD]) begin
                s_next.cmp_sh[i] = s_next.cmp_pre[i];
            end else if (upd) begin
                s_next.cmp_sh[i] = s_reg.cmp_pre[i];
            end
            match[i] = tick & (s_reg.cnt == s_reg.cmp_sh[i]);
            mode = s_reg.chctl[i*CH_STRIDE+CF_MODE +: 3];
            case (mode)
                OC_FREEZE:   s_next.chan_prep_sig[i] = s_reg.chan_prep_sig[i];
                OC_HIGH:     if (match[i]) s_next.chan_prep_sig[i] = 1'b1;
                OC_TOGGLE:   if (match[i]) s_next.chan_prep_sig[i] = ~s_reg.chan_prep_sig[i];
                OC_LOW:      if (match[i]) s_next.chan_prep_sig[i] = 1'b0;
                OC_FORCE_LO: s_next.chan_prep_sig[i] = 1'b0;
                OC_FORCE_HI: s_next.chan_prep_sig[i] = 1'b1;
                OC_PWM0: begin
                    if (s_reg.cmp_sh[i] > s_reg.rel_sh) s_next.chan_prep_sig[i] = 1'b0;
                    else if (up_dir) s_next.chan_prep_sig[i] = s_reg.cnt < s_reg.cmp_sh[i];
                    else s_next.chan_prep_sig[i] = s_reg.cnt <= s_reg.cmp_sh[i];
                end
                OC_PWM1: begin
                    if (s_reg.cmp_sh[i] > s_reg.rel_sh) s_next.chan_prep_sig[i] = 1'b1;
                    else if (up_dir) s_next.chan_prep_sig[i] = s_reg.cnt >= s_reg.cmp_sh[i];
                    else s_next.chan_prep_sig[i] = s_reg.cnt > s_reg.cmp_sh[i];
                end
                default:     s_next.chan_prep_sig[i] = s_reg.chan_prep_sig[i];
            endcase
            // external clear latch, set wins over the update release
            if (upd) s_next.clr_lat[i] = 1'b0;
            if (s_reg.chctl[i*CH_STRIDE+CF_CLR] && s_reg.filtered_ext_trig) begin
                s_next.clr_lat[i] = 1'b1;
            end
            if (s_next.clr_lat[i]) s_next.chan_prep_sig[i] = 1'b0;
            if (s_reg.chctl[i*CH_STRIDE+CF_OEN]) begin
                s_next.chan_out[i] = s_next.chan_prep_sig[i] ^ s_reg.chctl[i*CH_STRIDE+CF_POL];
            end else begin
                s_next.chan_out[i] = s_reg.chctl[i*CH_STRIDE+CF_POL];
            end
            if (match[i]) s_next.chan_match_flag[i] = 1'b1;
            if (match[i] && s_reg.inten[IE_DMA+i]) dma_ev = 1'b1;
        end
        s_next.irq = |(s_next.chan_match_flag & s_next.inten[IE_IRQ +: NCH]);
        // dma burst sequencing
        if (dtb && (BUS.wr || BUS.rd) && s_reg.dreq) begin
            if (s_reg.dleft == '0) begin
                s_next.dreq = 1'b0;
            end else begin
                s_next.dleft = s_reg.dleft - 5'h01;
                s_next.didx = s_reg.didx + 5'h01;
            end
        end
        if (dma_ev) begin
            s_next.dreq = 1'b1;
            s_next.didx = '0;
            s_next.dleft = s_reg.dcnt;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.rel_pre <= RELOAD_RST;
            s_reg.rel_sh <= RELOAD_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign RDATA = s_reg.rdata;
    assign CHAN_OUT = s_reg.chan_out;
    assign IRQ = s_reg.irq;
    assign DMA_REQ = s_reg.dreq;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    sequence s_buf_access;
        dtb && (BUS.wr || BUS.rd) && s_reg.dreq && !dma_ev;
    endsequence
    sequence s_force_hi;
        (s_reg.chctl[CF_MODE +: 3] == OC_FORCE_HI) && !s_reg.chctl[CF_CLR] && !s_reg.clr_lat[0];
    endsequence

    a_match_flag: assert property (match[0] |=> s_reg.chan_match_flag[0])
        else $error("match did not set flag");
    a_irq_gate: assert property (s_reg.irq |-> |(s_reg.chan_match_flag & s_reg.inten[NCH-1:0]))
        else $error("irq without enabled flag");
    a_dma_raise: assert property (match[0] && s_reg.inten[IE_DMA] |=> s_reg.dreq && s_reg.didx == '0)
        else $error("dma request missing");
    a_dma_quiet: assert property (!s_reg.dreq && !dma_ev |=> !s_reg.dreq)
        else $error("dma request without event");
    a_pol_out: assert property (s_reg.chctl[CF_OEN] |=> s_reg.chan_out[0] == (s_reg.chan_prep_sig[0] ^ $past(s_reg.chctl[CF_POL])))
        else $error("output polarity wrong");
    a_out_off: assert property (!s_reg.chctl[CF_OEN] |=> s_reg.chan_out[0] == $past(s_reg.chctl[CF_POL]))
        else $error("disabled output not inactive");
    a_set_high: assert property (match[0] && s_reg.chctl[CF_MODE +: 3] == OC_HIGH && !s_next.clr_lat[0] |=> s_reg.chan_prep_sig[0])
        else $error("set on match failed");
    a_force_hold: assert property (s_force_hi ##1 s_force_hi |-> s_reg.chan_prep_sig[0])
        else $error("forced active lost");
    a_clear_hold: assert property (s_reg.clr_lat[0] && !upd |=> s_reg.clr_lat[0] && !s_reg.chan_prep_sig[0])
        else $error("external clear released early");
    a_pwm_over: assert property (s_reg.chctl[CF_MODE +: 3] == OC_PWM0 && s_reg.cmp_sh[0] > s_reg.rel_sh |=> !s_reg.chan_prep_sig[0])
        else $error("pwm0 active above reload");
    a_halt_stop: assert property (halted || !s_reg.ctl[CTL_RUN] |=> $stable(s_reg.cnt))
        else $error("counter moved while held");
    a_burst_step: assert property (s_buf_access ##0 (s_reg.dleft != '0) |=> s_reg.dreq && s_reg.didx == $past(s_reg.didx) + 5'h01)
        else $error("burst did not advance");
    a_burst_end: assert property (s_buf_access ##0 (s_reg.dleft == '0) |=> !s_reg.dreq)
        else $error("burst did not end");
    a_upd_load: assert property (upd && s_reg.ctl[CTL_ARSE] && !BUS.wr |=> s_reg.rel_sh == $past(s_reg.rel_pre))
        else $error("reload shadow not loaded");

    // multi-step behaviours built from named steps
    sequence s_ext_clear;
        s_reg.chctl[CF_CLR] && s_reg.filtered_ext_trig;
    endsequence

    sequence s_dma_event;
        dma_ev;
    endsequence

    sequence s_up_wrap;
        tick && !s_reg.ctl[CTL_CENTER] && !s_reg.ctl[CTL_DOWN] && s_reg.cnt >= s_reg.rel_sh;
    endsequence

    a_irq_level: assert property (
        s_reg.irq == |(s_reg.chan_match_flag & s_reg.inten[IE_IRQ +: NCH]))
        else $error("irq level wrong");

    a_flag_keep: assert property (
        s_reg.chan_match_flag[0] && !(BUS.wr && widx == IX_FLAGS && BUS.wdata[0])
        |=> s_reg.chan_match_flag[0])
        else $error("flag lost");

    a_flag_clear: assert property (
        BUS.wr && widx == IX_FLAGS && BUS.wdata[0] && !match[0] |=> !s_reg.chan_match_flag[0])
        else $error("flag not cleared");

    a_flag_quiet: assert property (
        !s_reg.chan_match_flag[0] && !match[0] |=> !s_reg.chan_match_flag[0])
        else $error("flag set without match");

    a_toggle_match: assert property (
        match[0] && ch0_mode == OC_TOGGLE && !s_next.clr_lat[0]
        |=> s_reg.chan_prep_sig[0] != $past(s_reg.chan_prep_sig[0]))
        else $error("toggle on match failed");

    a_set_low: assert property (
        match[0] && ch0_mode == OC_LOW |=> !s_reg.chan_prep_sig[0])
        else $error("clear on match failed");

    a_freeze_keep: assert property (
        ch0_mode == OC_FREEZE && !s_next.clr_lat[0] |=> $stable(s_reg.chan_prep_sig[0]))
        else $error("frozen level changed");

    a_force_low: assert property (
        ch0_mode == OC_FORCE_LO |=> !s_reg.chan_prep_sig[0])
        else $error("forced inactive lost");

    a_force_high: assert property (
        ch0_mode == OC_FORCE_HI && !s_next.clr_lat[0] |=> s_reg.chan_prep_sig[0])
        else $error("forced active missing");

    a_pwm1_over: assert property (
        ch0_mode == OC_PWM1 && s_reg.cmp_sh[0] > s_reg.rel_sh && !s_next.clr_lat[0]
        |=> s_reg.chan_prep_sig[0])
        else $error("pwm1 inactive above reload");

    a_pwm0_up: assert property (
        ch0_mode == OC_PWM0 && up_dir && !(s_reg.cmp_sh[0] > s_reg.rel_sh) && !s_next.clr_lat[0]
        |=> s_reg.chan_prep_sig[0] == ($past(s_reg.cnt) < $past(s_reg.cmp_sh[0])))
        else $error("pwm0 up level wrong");

    a_pwm1_up: assert property (
        ch0_mode == OC_PWM1 && up_dir && !(s_reg.cmp_sh[0] > s_reg.rel_sh) && !s_next.clr_lat[0]
        |=> s_reg.chan_prep_sig[0] == ($past(s_reg.cnt) >= $past(s_reg.cmp_sh[0])))
        else $error("pwm1 up level wrong");

    a_clear_set: assert property (
        s_ext_clear |=> s_reg.clr_lat[0] && !s_reg.chan_prep_sig[0])
        else $error("external clear not applied");

    a_run_gate: assert property (
        !s_reg.ctl[CTL_RUN] |-> match == '0)
        else $error("match while stopped");

    a_halt_psc: assert property (
        halted |=> $stable(s_reg.psc_cnt))
        else $error("prescaler moved while held");

    a_buf_write: assert property (
        dtb && BUS.wr && widx == IX_RELOAD |=> s_reg.rel_pre == $past(BUS.wdata[CW-1:0]))
        else $error("buffer write not routed");

    a_burst_restart: assert property (
        s_dma_event |=> s_reg.dreq && s_reg.didx == '0 && s_reg.dleft == $past(s_reg.dcnt))
        else $error("burst not restarted");

    a_cmp_direct: assert property (
        !s_reg.chctl[CF_SHD] && BUS.wr && widx == IX_CMP0
        |=> s_reg.cmp_sh[0] == $past(BUS.wdata[CW-1:0]))
        else $error("direct compare write lost");

    a_cmp_shadow: assert property (
        s_reg.chctl[CF_SHD] && !upd |=> $stable(s_reg.cmp_sh[0]))
        else $error("shadow compare moved early");

    a_count_wrap: assert property (
        s_up_wrap |=> s_reg.cnt == '0)
        else $error("counter did not wrap");

    a_center_turn: assert property (
        tick && s_reg.ctl[CTL_CENTER] && !s_reg.dir_down && s_reg.cnt >= s_reg.rel_sh
        |=> s_reg.dir_down)
        else $error("center count did not turn");

    a_psc_load: assert property (
        upd |=> s_reg.psc_sh == $past(s_reg.psc_pre))
        else $error("prescaler shadow not loaded");
endmodule : tcp_compare

// file: rtl/tcp_pkg.sv
// Contract
// - on counter/compare match set, clear or toggle the channel level per control field
// - match sets the match flag; interrupt only when channel irq enable is 1
// - match raises the dma request only when channel dma enable is 1
// - enabled output equals prepare signal at polarity 0, inverted otherwise
// - control codes 3'b110 and 3'b111 select pwm mode 0 and mode 1
// - edge pwm period follows reload value, duty follows compare value
// - center pwm period is twice reload, duty twice compare
// - compare above reload: pwm0 always inactive, pwm1 always active
// - on match code 0 keeps level, code 1 drives high, code 3 drives low
// - code 4 forces inactive, code 5 forces active, ignoring comparison
// - pwm level chosen from count direction and counter versus compare
// - clear enable with high external trigger holds prepare low until update
// - per channel shadow enable picks buffered or direct compare writes
// - compare value may be rewritten while the counter runs
// - counting and compare matches start only after run enable is 1
// - transfer buffer accesses map to register at dma start address
// - each dma event gives burst count plus one requests at rising word addresses
// - every new dma event restarts the burst from the start address
// - debug halt with hold bit set stops the counter
// - update event loads reload, prescaler and compare shadows from preload
package tcp_pkg;
    localparam int NCH       = 4;
    localparam int CW        = 16;
    localparam int CHW       = 2;
    localparam int CH_STRIDE = 8;
    // register word indexes, byte address is four times the index
    localparam logic [5:0] IX_CTL    = 6'h00;
    localparam logic [5:0] IX_CHCTL  = 6'h01;
    localparam logic [5:0] IX_INTEN  = 6'h02;
    localparam logic [5:0] IX_FLAGS  = 6'h03;
    localparam logic [5:0] IX_COUNT  = 6'h04;
    localparam logic [5:0] IX_RELOAD = 6'h05;
    localparam logic [5:0] IX_PSC    = 6'h06;
    localparam logic [5:0] IX_CMP0   = 6'h07;
    localparam logic [5:0] IX_DMACFG = 6'h0B;
    localparam logic [5:0] IX_DMATB  = 6'h0C;
    // control bits
    localparam int CTL_RUN = 0;
    localparam int CTL_DOWN = 1;
    localparam int CTL_CENTER = 2;
    localparam int CTL_ARSE = 3;
    // per channel field positions inside each byte of the channel control word
    localparam int CF_MODE = 0;
    localparam int CF_SHD  = 3;
    localparam int CF_CLR  = 4;
    localparam int CF_POL  = 5;
    localparam int CF_OEN  = 6;
    localparam int IE_IRQ  = 0;
    localparam int IE_DMA  = 8;
    localparam int DC_CNT  = 8;
    localparam logic [CW-1:0] RELOAD_RST = 16'hFFFF;
    typedef enum logic [2:0] {
        OC_FREEZE = 3'h0, OC_HIGH = 3'h1, OC_TOGGLE = 3'h2, OC_LOW = 3'h3,
        OC_FORCE_LO = 3'h4, OC_FORCE_HI = 3'h5, OC_PWM0 = 3'h6, OC_PWM1 = 3'h7
    } tcp_oc_t;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } tcp_bus_t;
endpackage : tcp_pkg

// file: testbench/tcp_dma_model.sv
`timescale 1ns/1ps
module tcp_dma_model #(
    parameter int          GAP       = 2,
    parameter logic [31:0] DATA_BASE = 32'h0000_0100
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         dma_req,
    input  wire logic         en,
    output tcp_pkg::tcp_bus_t bus,
    output logic [7:0]        xfer_cnt
);
    import tcp_pkg::*;
    int gap_cnt;
    // memory to peripheral, buffer address only, one write per request seen
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus      <= '0;
            xfer_cnt <= 8'h00;
            gap_cnt  <= 0;
        end else if (bus.wr) begin
            bus.wr     <= 1'b0;
            bus.wdata  <= ~bus.wdata;
            gap_cnt    <= GAP;
        end else if (gap_cnt > 0) begin
            gap_cnt    <= gap_cnt - 1;
            bus.wdata  <= ~bus.wdata;
        end else if (en && dma_req) begin
            bus.wr    <= 1'b1;
            bus.addr  <= {IX_DMATB, 2'b00};
            bus.wdata <= DATA_BASE + 32'(xfer_cnt);
            xfer_cnt  <= xfer_cnt + 8'h01;
        end
    end
endmodule : tcp_dma_model

// file: testbench/tcp_compare_tb.sv
`timescale 1ns/1ps
module tcp_compare_tb;
    import tcp_pkg::*;
    logic           clk;
    logic           rstn;
    tcp_bus_t       tb_bus;
    tcp_bus_t       dma_bus;
    tcp_bus_t       bus;
    logic [31:0]    rdata;
    logic           ext_trig;
    logic           dbg_halt;
    logic           debug_hold;
    logic [NCH-1:0] chan_out;
    logic           irq;
    logic           dma_req;
    logic           dma_on;
    logic [7:0]     xfers;
    logic [31:0]    rd_val;
    logic [31:0]    a;
    logic [19:0]    e;
    int             errors;
    int             cmp_count;
    int             highs;
    localparam logic [19:0] TBL [12] = '{20'h11110, 20'h31100, 20'h01100, 20'h11300,
        20'h21108, 20'h41100, 20'h51110, 20'h51000, 20'h61104, 20'h7110C, 20'h65100,
        20'h75110};
    assign bus = dma_bus.wr ? dma_bus : tb_bus;
    tcp_compare i_dut (.CLK(clk), .RSTN(rstn), .BUS(bus), .RDATA(rdata), .EXT_TRIG(ext_trig),
        .DBG_HALT(dbg_halt), .DEBUG_HOLD(debug_hold), .CHAN_OUT(chan_out), .IRQ(irq),
        .DMA_REQ(dma_req));
    tcp_dma_model #(.GAP(2)) i_dma (.clk(clk), .rstn(rstn), .dma_req(dma_req), .en(dma_on),
        .bus(dma_bus), .xfer_cnt(xfers));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        // wait one unit before comparing; got and exp were already sampled when check was called
        #1;
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [5:0] ix, input logic [31:0] d);
        @(posedge clk);
        tb_bus.addr  <= {ix, 2'b00};
        tb_bus.wdata <= d;
        tb_bus.wr    <= 1'b1;
        @(posedge clk);
        tb_bus.wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] ix);
        @(posedge clk);
        tb_bus.addr <= {ix, 2'b00};
        tb_bus.rd   <= 1'b1;
        @(posedge clk);
        tb_bus.rd   <= 1'b0;
        #1 rd_val = rdata;
    endtask : rd
    task automatic measure(input int n);
        highs = 0;
        repeat (n) begin
            @(posedge clk);
            #1 if (chan_out[0] === 1'b1) highs++;
        end
    endtask : measure
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    initial begin
        errors = 0;
        cmp_count = 0;
        rstn = 1'b0;
        tb_bus = '0;
        ext_trig = 1'b0;
        dbg_halt = 1'b0;
        debug_hold = 1'b0;
        dma_on = 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        check(32'({chan_out, irq, dma_req}), 32'h0);
        rd(IX_RELOAD); check(rd_val, 32'h0000_FFFF);
        rd(IX_CTL); check(rd_val, 32'h0);
        rd(6'h20); check(rd_val, 32'h0);
        wr(IX_COUNT, 32'h5);
        repeat (5) @(posedge clk);
        rd(IX_COUNT); check(rd_val, 32'h0);
        $display("test reset done");
        wr(IX_RELOAD, 32'h3);
        wr(IX_PSC, 32'h0);
        wr(IX_CTL, 32'h1);
        foreach (TBL[i]) begin
            e = TBL[i];
            wr(IX_CMP0, 32'(e[15:12]));
            wr(IX_CHCTL, {25'h0, e[8], e[9], 2'b00, e[18:16]});
            repeat (8) @(posedge clk);
            measure(16);
            check(32'(highs), 32'(e[7:0]));
        end
        wr(IX_CTL, 32'h5);
        wr(IX_CMP0, 32'h1);
        wr(IX_CHCTL, 32'h46);
        repeat (8) @(posedge clk);
        measure(12);
        check(32'(highs), 32'h4);
        $display("test waveform done");
        wr(IX_CTL, 32'h0);
        rd(IX_FLAGS); check(32'(rd_val[0]), 32'h1);
        wr(IX_FLAGS, 32'hF);
        rd(IX_FLAGS); check(rd_val, 32'h0);
        check(32'(irq), 32'h0);
        wr(IX_INTEN, 32'h1);
        wr(IX_CTL, 32'h1);
        repeat (10) @(posedge clk);
        check(32'(irq), 32'h1);
        check(32'(dma_req), 32'h0);
        $display("test flag done");
        wr(IX_CMP0, 32'h0);
        wr(IX_CHCTL, 32'h57);
        repeat (8) @(posedge clk);
        check(32'(chan_out[0]), 32'h1);
        ext_trig <= 1'b1;
        repeat (10) @(posedge clk);
        check(32'(chan_out[0]), 32'h0);
        ext_trig <= 1'b0;
        highs = 0;
        while (chan_out[0] !== 1'b1 && highs < 20) begin
            @(posedge clk);
            highs++;
        end
        check(32'(chan_out[0]), 32'h1);
        $display("test clear done");
        wr(IX_CTL, 32'h0);
        wr(IX_INTEN, 32'h0);
        wr(IX_CHCTL, 32'h40);
        wr(IX_RELOAD, 32'd20);
        wr(IX_CMP0, 32'h2);
        wr(IX_DMACFG, {19'h0, 5'h01, 2'b00, IX_CMP0 + 6'h01});
        wr(IX_INTEN, 32'h100);
        dma_on <= 1'b1;
        wr(IX_CTL, 32'h1);
        repeat (90) @(posedge clk);
        dma_on <= 1'b0;
        repeat (10) @(posedge clk);
        wr(IX_CTL, 32'h0);
        check(32'(xfers > 8'h3), 32'h1);
        rd(IX_CMP0 + 6'h01); check(rd_val, 32'h100 + 32'((xfers - 8'h1) & 8'hFE));
        rd(IX_CMP0 + 6'h02); check(rd_val, 32'h100 + 32'((xfers - 8'h2) | 8'h01));
        rd(IX_CMP0 + 6'h03); check(rd_val, 32'h0);
        $display("test dma done");
        wr(IX_INTEN, 32'h0);
        wr(IX_CTL, 32'h1);
        dbg_halt <= 1'b1;
        debug_hold <= 1'b1;
        repeat (2) @(posedge clk);
        rd(IX_COUNT); a = rd_val;
        repeat (3) @(posedge clk);
        rd(IX_COUNT); check(rd_val, a);
        @(posedge clk);
        debug_hold <= 1'b0;
        rd(IX_COUNT); a = rd_val;
        repeat (3) @(posedge clk);
        rd(IX_COUNT); check(rd_val, (a + 32'd5) % 32'd21);
        $display("test debug done");
        test_done();
    end
endmodule : tcp_compare_tb
